// ### hw/csf_params.svh
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH

// APB register offsets (byte addresses)
`define CSF_CTRL0_OFS 8'h00
`define CSF_CTRL1_OFS 8'h04
`define CSF_FPER_OFS 8'h08
`define CSF_STAT_OFS 8'h0C

// control_reg_zero fields
`define CSF_CNT_LSB 0
`define CSF_CNT_W 3
// control_reg_one fields
`define CSF_EN_BIT 0
`define CSF_OPE_BIT 1
`define CSF_INV_BIT 3
`define CSF_SPEED_SELECT_BIT 4
`define CSF_SE_BIT 7
// status_control_reg fields
`define CSF_FILTERED_COMPARE_OUT_BIT 0
`define CSF_CFF_BIT 1
`define CSF_CFR_BIT 2
`define CSF_IEF_BIT 3
`define CSF_IER_BIT 4

// Reset values
`define CSF_CTRL0_RST 8'h00
`define CSF_CTRL1_RST 8'h00
`define CSF_FPER_RST 8'h00

`endif

// ### hw/csf_pkg.sv
package csf_pkg;
  typedef enum logic [1:0] {
    CSF_DISABLED = 2'b00,
    CSF_CONTINUOUS = 2'b01,
    CSF_SAMPLED = 2'b10,
    CSF_FILTERED = 2'b11
  } csf_mode_e;
  typedef enum logic [1:0] {
    CSF_RUN = 2'b00,
    CSF_WAIT = 2'b01,
    CSF_STOP = 2'b10,
    CSF_LEAK = 2'b11
  } csf_power_e;
endpackage

// ### hw/csf_filter.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "csf_params.svh"
module csf_filter (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_output,
  input wire csf_pkg::csf_power_e power_state,
  input wire logic debug_active,
  input wire logic leak_wakeup,
  output logic raw_compare_out,
  output logic filtered_compare_out,
  output logic cmp_pin_out,
  output logic cmp_pin_oe,
  output logic analog_enable,
  output logic high_speed,
  output logic irq,
  output logic wakeup_req
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] control_reg_zero;
  logic [7:0] control_reg_one;
  logic [7:0] filter_period_reg;
  logic rising_edge_flag;
  logic falling_edge_flag;
  logic rising_irq_enable;
  logic falling_irq_enable;
  logic [`CSF_CNT_W-1:0] filter_sample_count;
  logic [7:0] filter_sample_period;
  logic comp_enable;
  logic output_pin_enable;
  logic invert;
  logic speed_select;
  logic sample_enable;
  logic low_leak;
  logic soft_rst;
  logic wr;
  logic rd;
  csf_pkg::csf_mode_e mode;

  assign filter_sample_count = control_reg_zero[`CSF_CNT_LSB +: `CSF_CNT_W];
  assign filter_sample_period = filter_period_reg;
  assign comp_enable = control_reg_one[`CSF_EN_BIT];
  assign output_pin_enable = control_reg_one[`CSF_OPE_BIT];
  assign invert = control_reg_one[`CSF_INV_BIT];
  assign speed_select = control_reg_one[`CSF_SPEED_SELECT_BIT];
  assign sample_enable = control_reg_one[`CSF_SE_BIT];
  assign low_leak = (power_state == csf_pkg::CSF_LEAK);
  // Wakeup from low-leakage resets everything but the edge flags and the pin latch
  assign soft_rst = rst || leak_wakeup;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  always_ff @(posedge clk) begin
    if (soft_rst) begin
      control_reg_zero <= `CSF_CTRL0_RST;
      control_reg_one <= `CSF_CTRL1_RST;
      filter_period_reg <= `CSF_FPER_RST;
      rising_irq_enable <= 1'b0;
      falling_irq_enable <= 1'b0;
    end else if (wr) begin
      unique case (paddr)
        `CSF_CTRL0_OFS: control_reg_zero <= pwdata[7:0];
        `CSF_CTRL1_OFS: control_reg_one <= pwdata[7:0];
        `CSF_FPER_OFS: filter_period_reg <= pwdata[7:0];
        `CSF_STAT_OFS: begin
          rising_irq_enable <= pwdata[`CSF_IER_BIT];
          falling_irq_enable <= pwdata[`CSF_IEF_BIT];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  // Sampling is digital; low-leakage has no running clock so only continuous works
  always_comb begin
    if (!comp_enable) begin
      mode = csf_pkg::CSF_DISABLED;
    end else if (low_leak || sample_enable || filter_sample_count == '0 || filter_sample_period == 8'h00) begin
      mode = csf_pkg::CSF_CONTINUOUS;
    end else if (filter_sample_count > `CSF_CNT_W'(1)) begin
      mode = csf_pkg::CSF_FILTERED;
    end else begin
      mode = csf_pkg::CSF_SAMPLED;
    end
  end

  assign analog_enable = comp_enable;
  assign high_speed = comp_enable && speed_select && !low_leak;
  assign raw_compare_out = comp_enable && (comparator_output ^ invert);

  // ----------------------------------------
  // Sample divider
  // ----------------------------------------
  logic [7:0] div_cnt;
  logic sample_tick;
  logic filt_on;

  assign filt_on = (mode == csf_pkg::CSF_SAMPLED) || (mode == csf_pkg::CSF_FILTERED);
  assign sample_tick = filt_on && (div_cnt == filter_sample_period - 8'h01);

  always_ff @(posedge clk) begin
    if (soft_rst || !filt_on) begin
      div_cnt <= 8'h00;
    end else if (sample_tick) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // ----------------------------------------
  // Sample and filter
  // ----------------------------------------
  logic raw_sync;
  logic held;
  logic [`CSF_CNT_W-1:0] agree_cnt;

  always_ff @(posedge clk) begin
    if (soft_rst) begin
      raw_sync <= 1'b0;
    end else begin
      raw_sync <= raw_compare_out;
    end
  end

  // The agreement counter restarts on any sample that matches the held value
  always_ff @(posedge clk) begin
    if (soft_rst || !filt_on) begin
      held <= 1'b0;
      agree_cnt <= '0;
    end else if (sample_tick) begin
      if (raw_compare_out == held) begin
        agree_cnt <= '0;
      end else if (mode == csf_pkg::CSF_SAMPLED || agree_cnt == filter_sample_count - `CSF_CNT_W'(1)) begin
        held <= raw_compare_out;
        agree_cnt <= '0;
      end else begin
        agree_cnt <= agree_cnt + `CSF_CNT_W'(1);
      end
    end
  end

  // ----------------------------------------
  // Output, edges, interrupt
  // ----------------------------------------
  logic next_filtered_compare_out;
  logic pin_latch;

  assign next_filtered_compare_out = filt_on ? held : raw_sync;

  always_ff @(posedge clk) begin
    if (soft_rst) begin
      filtered_compare_out <= 1'b0;
    end else begin
      filtered_compare_out <= next_filtered_compare_out;
    end
  end

  // Flags survive the low-leakage wakeup, cleared by writing one
  always_ff @(posedge clk) begin
    if (rst) begin
      rising_edge_flag <= 1'b0;
      falling_edge_flag <= 1'b0;
    end else begin
      if (next_filtered_compare_out && !filtered_compare_out) begin
        rising_edge_flag <= 1'b1;
      end else if (wr && paddr == `CSF_STAT_OFS && pwdata[`CSF_CFR_BIT]) begin
        rising_edge_flag <= 1'b0;
      end
      if (!next_filtered_compare_out && filtered_compare_out) begin
        falling_edge_flag <= 1'b1;
      end else if (wr && paddr == `CSF_STAT_OFS && pwdata[`CSF_CFF_BIT]) begin
        falling_edge_flag <= 1'b0;
      end
    end
  end

  assign irq = (rising_irq_enable && rising_edge_flag) || (falling_irq_enable && falling_edge_flag);
  assign wakeup_req = irq && (power_state != csf_pkg::CSF_RUN);

  // Low-leakage freezes the pin at its last value
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_latch <= 1'b0;
    end else if (!low_leak) begin
      pin_latch <= filtered_compare_out;
    end
  end

  assign cmp_pin_out = low_leak ? pin_latch : filtered_compare_out;
  assign cmp_pin_oe = output_pin_enable;

  always_ff @(posedge clk) begin
    if (soft_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `CSF_CTRL0_OFS: prdata <= {24'h000000, control_reg_zero};
        `CSF_CTRL1_OFS: prdata <= {24'h000000, control_reg_one};
        `CSF_FPER_OFS: prdata <= {24'h000000, filter_period_reg};
        `CSF_STAT_OFS: prdata <= {27'h0, rising_irq_enable, falling_irq_enable, rising_edge_flag,
                                  falling_edge_flag, filtered_compare_out};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  irq_pairs_a: assert property (@(posedge clk) disable iff (rst)
    irq == ((rising_irq_enable && rising_edge_flag) || (falling_irq_enable && falling_edge_flag)))
    else $error("irq does not match enables and flags");
  disabled_zero_a: assert property (@(posedge clk) disable iff (rst)
    !comp_enable |-> !raw_compare_out) else $error("raw output high while disabled");
  rise_flag_a: assert property (@(posedge clk) disable iff (rst)
    $rose(filtered_compare_out) |-> rising_edge_flag) else $error("rising flag missed");
  fall_flag_a: assert property (@(posedge clk) disable iff (rst)
    $fell(filtered_compare_out) |-> falling_edge_flag) else $error("falling flag missed");
  filter_off_a: assert property (@(posedge clk) disable iff (rst)
    filter_sample_period == 8'h00 |=> div_cnt == 8'h00 && !held) else $error("filter not reset");
  leak_speed_a: assert property (@(posedge clk) disable iff (rst)
    low_leak |-> !high_speed) else $error("high speed in low leakage");
  filt_hold_a: assert property (@(posedge clk) disable iff (rst)
    mode == csf_pkg::CSF_FILTERED && $changed(held) |-> $past(sample_tick)) else $error("filter moved off tick");
  leak_pin_a: assert property (@(posedge clk) disable iff (rst)
    low_leak && $past(low_leak) |-> $stable(cmp_pin_out)) else $error("pin moved in low leakage");
  flags_keep_a: assert property (@(posedge clk) disable iff (rst)
    leak_wakeup && !wr |=> rising_edge_flag == $past(rising_edge_flag)) else $error("flag lost on wakeup");
  start_zero_a: assert property (@(posedge clk)
    rst |=> !filtered_compare_out) else $error("output not zero after reset");

  // ----------------------------------------
  // Filter checks
  // ----------------------------------------
  // A period change without first going through zero is a software fault, so these hold only
  div_bound_a: assert property (@(posedge clk) disable iff (soft_rst)
    filt_on |-> div_cnt < filter_sample_period)
    else $error("divider ran past the period");
  tick_gap_a: assert property (@(posedge clk) disable iff (soft_rst)
    sample_tick && filter_sample_period > 8'h01 |=> !sample_tick)
    else $error("sample ticks too close");
  off_quiet_a: assert property (@(posedge clk) disable iff (soft_rst)
    filter_sample_period == 8'h00 |-> !sample_tick)
    else $error("tick with period zero");
  first_zero_a: assert property (@(posedge clk) disable iff (soft_rst)
    $rose(filt_on) |-> !held)
    else $error("filter did not start at zero");
  sampled_take_a: assert property (@(posedge clk) disable iff (soft_rst)
    mode == csf_pkg::CSF_SAMPLED && sample_tick |=> held == $past(raw_compare_out))
    else $error("sampled mode missed a sample");
  agree_restart_a: assert property (@(posedge clk) disable iff (soft_rst)
    mode == csf_pkg::CSF_FILTERED && sample_tick && raw_compare_out == held |=> agree_cnt == '0)
    else $error("agreeing sample did not restart count");
  filt_step_a: assert property (@(posedge clk) disable iff (soft_rst)
    mode == csf_pkg::CSF_FILTERED && sample_tick && raw_compare_out != held &&
    agree_cnt != filter_sample_count - `CSF_CNT_W'(1) |=> $stable(held))
    else $error("filter changed too early");
  filt_take_a: assert property (@(posedge clk) disable iff (soft_rst)
    mode == csf_pkg::CSF_FILTERED && sample_tick && raw_compare_out != held &&
    agree_cnt == filter_sample_count - `CSF_CNT_W'(1) |=> held == $past(raw_compare_out))
    else $error("filter missed a full run");
  // Continuous output is two flops behind the raw value
  cont_follow_a: assert property (@(posedge clk) disable iff (soft_rst)
    !filt_on |=> filtered_compare_out == $past(raw_sync))
    else $error("continuous output lost sync");
  filt_follow_a: assert property (@(posedge clk) disable iff (soft_rst)
    filt_on |=> filtered_compare_out == $past(held))
    else $error("filtered output lags held value");
  raw_path_a: assert property (@(posedge clk) disable iff (rst)
    comp_enable |-> raw_compare_out == (comparator_output ^ invert))
    else $error("raw output wrong polarity");
  stat_read_a: assert property (@(posedge clk) disable iff (soft_rst)
    psel && !penable && !pwrite && paddr == `CSF_STAT_OFS |=> prdata[`CSF_FILTERED_COMPARE_OUT_BIT] == $past(filtered_compare_out))
    else $error("status read shows wrong output");

  // ----------------------------------------
  // Flag checks
  // ----------------------------------------
  // Set wins over a clear in the same cycle so no edge is ever lost
  rise_set_a: assert property (@(posedge clk) disable iff (rst)
    next_filtered_compare_out && !filtered_compare_out |=> rising_edge_flag)
    else $error("rising edge not flagged");
  fall_set_a: assert property (@(posedge clk) disable iff (rst)
    !next_filtered_compare_out && filtered_compare_out |=> falling_edge_flag)
    else $error("falling edge not flagged");
  rise_clear_a: assert property (@(posedge clk) disable iff (rst)
    wr && paddr == `CSF_STAT_OFS && pwdata[`CSF_CFR_BIT] && !(next_filtered_compare_out && !filtered_compare_out)
    |=> !rising_edge_flag)
    else $error("rising flag not cleared");
  irq_drop_a: assert property (@(posedge clk) disable iff (rst)
    !rising_edge_flag && !falling_edge_flag |-> !irq)
    else $error("irq without a flag");

  // ----------------------------------------
  // Power checks
  // ----------------------------------------
  leak_regs_a: assert property (@(posedge clk) disable iff (rst)
    leak_wakeup |=> control_reg_one == `CSF_CTRL1_RST && filter_period_reg == `CSF_FPER_RST)
    else $error("controls survived wakeup");
  leak_cont_a: assert property (@(posedge clk) disable iff (rst)
    low_leak |-> !filt_on)
    else $error("sampling in low leakage");
  wake_req_a: assert property (@(posedge clk) disable iff (rst)
    power_state != csf_pkg::CSF_RUN && irq |-> wakeup_req)
    else $error("no wakeup for pending irq");
  speed_sel_a: assert property (@(posedge clk) disable iff (rst)
    !low_leak |-> high_speed == (comp_enable && speed_select))
    else $error("speed select ignored");
  pin_live_a: assert property (@(posedge clk) disable iff (rst)
    !low_leak |-> cmp_pin_out == filtered_compare_out)
    else $error("pin does not follow output");
  debug_run_a: assert property (@(posedge clk) disable iff (rst)
    debug_active && comp_enable |-> analog_enable)
    else $error("comparator frozen in debug");

  cov_filtered_c: cover property (@(posedge clk) mode == csf_pkg::CSF_FILTERED && $rose(held));
  cov_sampled_c: cover property (@(posedge clk) mode == csf_pkg::CSF_SAMPLED && $fell(held));
  cov_irq_c: cover property (@(posedge clk) $rose(irq));
  cov_leak_c: cover property (@(posedge clk) leak_wakeup && rising_edge_flag);
  cov_restart_c: cover property (@(posedge clk) mode == csf_pkg::CSF_FILTERED && sample_tick && agree_cnt != '0);

endmodule

// ### testbench/csf_cmp_core.sv
`timescale 1ns/1ps
// ----------------------------------------
// Analog comparator core model
// ----------------------------------------
// One clock of delay stands in for the analog propagation delay.
// While unpowered, the output toggles every cycle, so the block must mask it.
module csf_cmp_core (
  input wire logic clk,
  input wire logic level_req,
  input wire logic powered,
  output logic comparator_output
);
  initial comparator_output = 1'b0;
  always @(posedge clk) begin
    comparator_output <= powered ? level_req : ~comparator_output;
  end
endmodule

// ### testbench/test_comparator_sample_filter_irq.sv
`timescale 1ns/1ps
`include "csf_params.svh"
module test_comparator_sample_filter_irq;
  localparam logic [31:0] EN = 32'h1 << `CSF_EN_BIT;
  localparam logic [31:0] OUTPUT_PIN_ENABLE = 32'h1 << `CSF_OPE_BIT;
  localparam logic [31:0] INV = 32'h1 << `CSF_INV_BIT;
  localparam logic [31:0] HS = 32'h1 << `CSF_SPEED_SELECT_BIT;
  localparam logic [31:0] CO = 32'h1 << `CSF_FILTERED_COMPARE_OUT_BIT;
  localparam logic [31:0] CFF = 32'h1 << `CSF_CFF_BIT;
  localparam logic [31:0] RISING_EDGE_FLAG = 32'h1 << `CSF_CFR_BIT;
  localparam logic [31:0] IE = (32'h1 << `CSF_IEF_BIT) | (32'h1 << `CSF_IER_BIT);
  localparam int P = 4;
  logic clk, rst, psel, penable, pwrite, debug_active, leak_wakeup, cmp_level;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  csf_pkg::csf_power_e power_state;
  wire logic [31:0] prdata;
  wire logic pready, cmp_o, raw_o, filt_o, pin_o, pin_oe, an_en, hs_o, irq, wake;
  int err_total, checks_done;
  csf_cmp_core core (.clk(clk), .level_req(cmp_level), .powered(an_en), .comparator_output(cmp_o));
  csf_filter dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(), .comparator_output(cmp_o),
    .power_state(power_state), .debug_active(debug_active), .leak_wakeup(leak_wakeup),
    .raw_compare_out(raw_o), .filtered_compare_out(filt_o), .cmp_pin_out(pin_o), .cmp_pin_oe(pin_oe),
    .analog_enable(an_en), .high_speed(hs_o), .irq(irq), .wakeup_req(wake));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Holds the request until pready is seen; read data is taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      test_done();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Latency window: no earlier than cnt-1 full periods, no later than cnt periods plus sync
  task automatic filt_run(input int cnt);
    int n;
    cmp_level <= 1'b0;
    apb(1'b1, `CSF_FPER_OFS, 32'h0);
    apb(1'b1, `CSF_CTRL0_OFS, 32'(cnt));
    apb(1'b1, `CSF_CTRL1_OFS, EN);
    apb(1'b1, `CSF_FPER_OFS, 32'(P));
    chk(32'(filt_o), 32'h0);
    cmp_level <= 1'b1;
    n = 0;
    while (filt_o !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) begin
      err_total++;
      test_done();
    end
    chk(32'(n >= (cnt - 1) * P), 32'h1);
    chk(32'(n <= cnt * P + 4), 32'h1);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    debug_active = 1'b0;
    leak_wakeup = 1'b0;
    cmp_level = 1'b1;
    power_state = csf_pkg::CSF_RUN;
    err_total = 0;
    checks_done = 0;
    cyc(2);
    rst <= 1'b0;
    rchk(`CSF_CTRL0_OFS, 32'h0);
    rchk(`CSF_CTRL1_OFS, 32'h0);
    rchk(`CSF_FPER_OFS, 32'h0);
    rchk(`CSF_STAT_OFS, 32'h0);
    rchk(8'h10, 32'h0);
    chk(32'(raw_o), 32'h0);
    apb(1'b1, `CSF_STAT_OFS, IE);
    debug_active <= 1'b1;
    apb(1'b1, `CSF_CTRL1_OFS, EN);
    cyc(4);
    chk(32'(raw_o), 32'h1);
    chk(32'(filt_o), 32'h1);
    chk(32'(irq), 32'h1);
    rchk(`CSF_STAT_OFS, IE | RISING_EDGE_FLAG | CO);
    apb(1'b1, `CSF_STAT_OFS, IE | RISING_EDGE_FLAG);
    cyc(1);
    chk(32'(irq), 32'h0);
    apb(1'b1, `CSF_CTRL1_OFS, EN | INV);
    cyc(4);
    chk(32'(raw_o), 32'h0);
    rchk(`CSF_STAT_OFS, IE | CFF);
    chk(32'(irq), 32'h1);
    apb(1'b1, `CSF_CTRL1_OFS, EN | INV | HS | OUTPUT_PIN_ENABLE);
    power_state <= csf_pkg::CSF_STOP;
    cyc(2);
    chk(32'(hs_o), 32'h1);
    chk(32'(wake), 32'h1);
    chk({31'h0, pin_oe} | {31'h0, pin_o} << 1, 32'h1);
    apb(1'b1, `CSF_CTRL1_OFS, EN | INV | OUTPUT_PIN_ENABLE);
    cyc(1);
    chk(32'(hs_o), 32'h0);
    power_state <= csf_pkg::CSF_LEAK;
    cyc(2);
    chk(32'(hs_o), 32'h0);
    cmp_level <= 1'b0;
    cyc(4);
    chk(32'(pin_o), 32'h0);
    leak_wakeup <= 1'b1;
    cyc(1);
    leak_wakeup <= 1'b0;
    power_state <= csf_pkg::CSF_RUN;
    rchk(`CSF_CTRL1_OFS, 32'h0);
    rchk(`CSF_STAT_OFS, CFF | RISING_EDGE_FLAG);
    apb(1'b1, `CSF_STAT_OFS, CFF | RISING_EDGE_FLAG);
    filt_run(1);
    filt_run(3);
    cmp_level <= 1'b0;
    apb(1'b1, `CSF_FPER_OFS, 32'h0);
    cyc(4);
    chk(32'(filt_o), 32'h0);
    test_done();
  end
endmodule
